// [plc_loop_core.sv]
// Purpose: Digital loop filter, saturation feedforward and monitor of a step-down converter.
// Assumes: APB register access, one switching-cycle strobe, an external shared 8-bit converter.
// Notes:   Duty is a 16-bit fraction of the switching period.
`include "plc_map.svh"
`timescale 1ns/1ps
`default_nettype none
module plc_loop_core #(
    parameter int SLOT_CYCLES = `PLC_SLOT_CYCLES
) (
    // Clock, reset and enable.
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic               ce,
    // APB slave.
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [7:0]         paddr,
    input  wire logic [31:0]        pwdata,
    output logic                    pready,
    output logic                    pslverr,
    output logic [31:0]             prdata,
    // Control loop.
    input  wire logic               cycle_strobe,
    input  wire plc_pkg::plc_err_t  loop_error,
    output logic [15:0]             duty_out,
    // Shared monitor converter.
    output plc_pkg::plc_chan_t      adc_sel,
    input  wire logic [7:0]         adc_data,
    // Current share line.
    input  wire logic [7:0]         share_in,
    output logic [7:0]              share_out
);
    import plc_pkg::*;

    logic [7:0]         duty_limit_reg;
    logic [7:0]         coef_reg [0:10];
    logic [7:0]         volt_mon_reg;
    logic [7:0]         curr_mon_reg;
    logic [7:0]         temp_mon_reg;
    logic [15:0]        win_high_reg;
    logic [15:0]        win_low_reg;
    logic [7:0]         ctrl_reg;
    logic [7:0]         temp_coef_reg;
    logic [31:0]        prdata_reg;
    logic [15:0]        duty_reg;
    logic [15:0]        duty_next;
    plc_err_t           err_hist [0:2];
    logic [15:0]        duty_hist [0:2];
    logic [7:0]         adc_s1;
    logic [7:0]         adc_s2;
    logic [7:0]         share_s1;
    logic [7:0]         share_s2;
    logic [31:0]        slot_cnt;
    plc_chan_t          chan_reg;

    // Clamp a signed value to the range 0 .. lim.
    function automatic logic [15:0] clamp_duty(input logic signed [39:0] v,
                                               input logic [15:0] lim);
        if (v < 40'sd0) begin
            clamp_duty = 16'h0000;
        end else if (v > $signed({24'h000000, lim})) begin
            clamp_duty = lim;
        end else begin
            clamp_duty = v[15:0];
        end
    endfunction : clamp_duty

    // Signed product widened to the accumulator.
    // Both operands are widened first so the product keeps all of its bits.
    function automatic logic signed [39:0] mul40(input logic signed [15:0] a,
                                                 input logic signed [16:0] b);
        mul40 = 40'(a) * 40'(b);
    endfunction : mul40

    // APB decode.
    wire        setup     = psel & ~penable;
    wire        wr_strobe = psel & penable & pwrite & ce;
    wire        is_coef   = (paddr >= `PLC_COEF_FIRST_OFF) && (paddr <= `PLC_COEF_LAST_OFF);
    wire [3:0]  coef_idx  = 4'((paddr - `PLC_COEF_FIRST_OFF) >> 2);
    wire        aligned   = (paddr[1:0] == 2'b00);
    wire        mapped    = aligned && (paddr <= `PLC_DUTY_STAT_OFF);
    wire        hit_limit = (paddr == `PLC_DUTY_LIMIT_OFF);
    wire        hit_winh  = (paddr == `PLC_WIN_HIGH_OFF);
    wire        hit_winl  = (paddr == `PLC_WIN_LOW_OFF);
    wire        hit_ctrl  = (paddr == `PLC_CTRL_OFF);
    wire        hit_tcoef = (paddr == `PLC_TEMP_COEF_OFF);

    // Every register answers in the first access cycle, so there are no wait states.
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~mapped;
    assign prdata  = prdata_reg;

    // Unmapped and misaligned words read as zero.
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h00000000;
        if (is_coef && aligned) begin
            rd_mux = {24'h000000, coef_reg[coef_idx]};
        end else begin
            case (paddr)
                `PLC_DUTY_LIMIT_OFF: rd_mux = {24'h000000, duty_limit_reg};
                `PLC_VOLT_MON_OFF:   rd_mux = {24'h000000, volt_mon_reg};
                `PLC_CURR_MON_OFF:   rd_mux = {24'h000000, curr_mon_reg};
                `PLC_TEMP_MON_OFF:   rd_mux = {24'h000000, temp_mon_reg};
                `PLC_WIN_HIGH_OFF:   rd_mux = {16'h0000, win_high_reg};
                `PLC_WIN_LOW_OFF:    rd_mux = {16'h0000, win_low_reg};
                `PLC_CTRL_OFF:       rd_mux = {24'h000000, ctrl_reg};
                `PLC_TEMP_COEF_OFF:  rd_mux = {24'h000000, temp_coef_reg};
                `PLC_DUTY_STAT_OFF:  rd_mux = {16'h0000, duty_reg};
                default:             rd_mux = 32'h00000000;
            endcase
        end
    end

    // Read data is captured in the setup cycle so it comes from a flop in the access cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h00000000;
        end else if (ce && setup && !pwrite) begin
            prdata_reg <= rd_mux;
        end
    end

    // Software-written configuration.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            duty_limit_reg <= `PLC_DUTY_LIMIT_RST;
            win_high_reg   <= `PLC_WIN_RST;
            win_low_reg    <= `PLC_WIN_RST;
            ctrl_reg       <= `PLC_CTRL_RST;
            temp_coef_reg  <= 8'h00;
        end else if (wr_strobe) begin
            if (hit_limit) duty_limit_reg <= pwdata[7:0];
            if (hit_winh)  win_high_reg   <= pwdata[15:0];
            if (hit_winl)  win_low_reg    <= pwdata[15:0];
            if (hit_ctrl)  ctrl_reg       <= pwdata[7:0];
            if (hit_tcoef) temp_coef_reg  <= pwdata[7:0];
        end
    end

    // Eleven byte registers: four numerator high/low pairs, then three denominators.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 11; i++) coef_reg[i] <= 8'h00;
        end else if (wr_strobe && is_coef && aligned) begin
            coef_reg[coef_idx] <= pwdata[7:0];
        end
    end

    // Coefficient views.
    wire signed [15:0] num0 = $signed({coef_reg[0], coef_reg[1]});
    wire signed [15:0] num1 = $signed({coef_reg[2], coef_reg[3]});
    wire signed [15:0] num2 = $signed({coef_reg[4], coef_reg[5]});
    wire signed [15:0] num3 = $signed({coef_reg[6], coef_reg[7]});
    wire signed [15:0] den1 = 16'($signed(coef_reg[8]));
    wire signed [15:0] den2 = 16'($signed(coef_reg[9]));
    wire signed [15:0] den3 = 16'($signed(coef_reg[10]));

    // Duty ceiling: six bits in 1/64 steps, placed at the top of the 16-bit fraction.
    wire [15:0] duty_limit = {duty_limit_reg[`PLC_LIMIT_MSB:`PLC_LIMIT_LSB], 10'h000};
    wire        high_saturation_enable = duty_limit_reg[`PLC_HIGH_SAT_BIT];
    wire        low_saturation_enable  = duty_limit_reg[`PLC_LOW_SAT_BIT];
    wire        share_en   = ctrl_reg[`PLC_SHARE_BIT];
    wire        loop_en    = ctrl_reg[`PLC_LOOP_BIT];

    // Share correction pulls this converter's current toward the common line level.
    wire signed [15:0] share_err = share_en ?
        16'(($signed({8'h00, share_s2}) - $signed({8'h00, curr_mon_reg})) <<< `PLC_SHARE_GAIN)
        : 16'sh0000;
    wire signed [15:0] err_now = 16'(loop_error + share_err);

    // Difference equation: u = sum Ck*e[n-k] >> N - sum Bk*u[n-k] >> D.
    // A first denominator of minus one in the 1/64 scale makes pole 1 the integrator.
    wire signed [39:0] num_sum = mul40(num0, 17'(err_now))
                               + mul40(num1, 17'(err_hist[0]))
                               + mul40(num2, 17'(err_hist[1]))
                               + mul40(num3, 17'(err_hist[2]));
    wire signed [39:0] den_sum = mul40(den1, $signed({1'b0, duty_hist[0]}))
                               + mul40(den2, $signed({1'b0, duty_hist[1]}))
                               + mul40(den3, $signed({1'b0, duty_hist[2]}));
    wire signed [39:0] filt_raw = (num_sum >>> `PLC_NUM_SHIFT) - (den_sum >>> `PLC_DEN_SHIFT);

    // Window comparators: positive error means the output sagged.
    wire above_win = err_now >  $signed(win_high_reg);
    wire below_win = err_now < -$signed(win_low_reg);
    // The low threshold is held as a magnitude and negated at the compare.

    // Saturation jumps straight to a rail in this cycle; the filter history is loaded
    // with that rail so the integrator does not wind up past it.
    always_comb begin
        if (high_saturation_enable && above_win) begin
            duty_next = duty_limit;
        end else if (low_saturation_enable && below_win) begin
            duty_next = 16'h0000;
        end else begin
            duty_next = clamp_duty(filt_raw, duty_limit);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            duty_reg <= 16'h0000;
            for (int i = 0; i < 3; i++) begin
                err_hist[i]  <= 16'sh0000;
                duty_hist[i] <= 16'h0000;
            end
        end else if (ce && cycle_strobe && loop_en) begin
            duty_reg     <= duty_next;
            err_hist[0]  <= err_now;
            err_hist[1]  <= err_hist[0];
            err_hist[2]  <= err_hist[1];
            duty_hist[0] <= duty_next;
            duty_hist[1] <= duty_hist[0];
            duty_hist[2] <= duty_hist[1];
        end
    end

    // With ce low or the loop disabled the duty and its history simply hold.
    assign duty_out = duty_reg;

    // Converter data and the share line come from outside this clock domain.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            adc_s1   <= 8'h00;
            adc_s2   <= 8'h00;
            share_s1 <= 8'h00;
            share_s2 <= 8'h00;
        end else if (ce) begin
            adc_s1   <= adc_data;
            adc_s2   <= adc_s1;
            share_s1 <= share_in;
            share_s2 <= share_s1;
        end
    end

    // Temperature correction of the current reading against a fixed reference.
    wire signed [9:0]  temp_delta = $signed({2'b00, temp_mon_reg}) - $signed(10'(`PLC_TEMP_REF));
    wire signed [31:0] curr_adj_w = $signed({1'b0, adc_s2}) * temp_delta
                                  * $signed({1'b0, temp_coef_reg});
    wire signed [31:0] curr_corr  = $signed({24'h000000, adc_s2})
                                  + (curr_adj_w >>> `PLC_TCOMP_SHIFT);
    wire [7:0] curr_fixed = (curr_corr < 32'sd0) ? 8'h00 :
                            (curr_corr > 32'sd255) ? 8'hFF : curr_corr[7:0];

    // Channel scheduler: each slot lets the mux settle, then the result is stored.
    wire slot_end = (slot_cnt == 32'(SLOT_CYCLES - 1));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slot_cnt <= 32'h00000000;
            chan_reg <= PLC_CH_VOLT;
        end else if (ce) begin
            slot_cnt <= slot_end ? 32'h00000000 : slot_cnt + 32'h00000001;
            if (slot_end) begin
                case (chan_reg)
                    PLC_CH_VOLT: chan_reg <= PLC_CH_CURR;
                    PLC_CH_CURR: chan_reg <= PLC_CH_TEMP;
                    PLC_CH_TEMP: chan_reg <= PLC_CH_VOLT;
                    default:     chan_reg <= PLC_CH_VOLT;
                endcase
            end
        end
    end

    assign adc_sel = chan_reg;

    // A slot must outlast the mux settling and the two synchroniser stages.

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            volt_mon_reg <= 8'h00;
            curr_mon_reg <= 8'h00;
            temp_mon_reg <= 8'h00;
        end else if (ce && slot_end) begin
            case (chan_reg)
                PLC_CH_VOLT: volt_mon_reg <= adc_s2;
                PLC_CH_CURR: curr_mon_reg <= curr_fixed;
                PLC_CH_TEMP: temp_mon_reg <= adc_s2;
                default:     temp_mon_reg <= temp_mon_reg;
            endcase
        end
    end

    // Paralleled units see the temperature-corrected reading, not the raw one.
    assign share_out = curr_mon_reg;
endmodule : plc_loop_core
`default_nettype wire

// [plc_map.svh]
// Purpose: Register offsets, reset values and timing counts of the loop compensator.
// Assumes: 32-bit APB, one register per aligned word, 100 MHz pclk.
// Notes:   Offsets are byte addresses.
`ifndef PLC_MAP_SVH
`define PLC_MAP_SVH
`define PLC_DUTY_LIMIT_OFF   8'h00
`define PLC_COEF_FIRST_OFF   8'h04
`define PLC_COEF_LAST_OFF    8'h2C
`define PLC_VOLT_MON_OFF     8'h30
`define PLC_CURR_MON_OFF     8'h34
`define PLC_TEMP_MON_OFF     8'h38
`define PLC_WIN_HIGH_OFF     8'h3C
`define PLC_WIN_LOW_OFF      8'h40
`define PLC_CTRL_OFF         8'h44
`define PLC_TEMP_COEF_OFF    8'h48
`define PLC_DUTY_STAT_OFF    8'h4C
`define PLC_DUTY_LIMIT_RST   8'hE8
`define PLC_WIN_RST          16'h0400
`define PLC_CTRL_RST         8'h02
`define PLC_TEMP_REF         8'h19
`define PLC_HIGH_SAT_BIT     1
`define PLC_LOW_SAT_BIT      0
`define PLC_LIMIT_MSB        7
`define PLC_LIMIT_LSB        2
`define PLC_SHARE_BIT        0
`define PLC_LOOP_BIT         1
`define PLC_CLK_HZ           100000000
`define PLC_MON_RATE_HZ      1000
`define PLC_MON_CHANNELS     3
`define PLC_SLOT_CYCLES      (`PLC_CLK_HZ / (`PLC_MON_RATE_HZ * `PLC_MON_CHANNELS))
`define PLC_NUM_SHIFT        12
`define PLC_DEN_SHIFT        6
`define PLC_TCOMP_SHIFT      14
`define PLC_SHARE_GAIN       2
`endif

// [plc_pkg.sv]
// Purpose: Types shared by the loop compensator.
// Assumes: Nothing beyond plc_map.svh.
// Notes:   Monitor channel order is voltage, current, temperature.
package plc_pkg;
    typedef enum logic [1:0] {
        PLC_CH_VOLT = 2'b00,
        PLC_CH_CURR = 2'b01,
        PLC_CH_TEMP = 2'b10
    } plc_chan_t;
    typedef logic signed [15:0] plc_err_t;
endpackage : plc_pkg

// [plc_loop_monitor.sv]
// Purpose: Concurrent checks on the loop compensator ports.
// Assumes: Window and control registers stay at their reset values.
// Notes:   The duty limit register is shadowed from APB writes.
`include "plc_map.svh"
`timescale 1ns/1ps
`default_nettype none
module plc_loop_monitor #(
    parameter int SLOT_CYCLES = `PLC_SLOT_CYCLES
) (
    // Clock, reset and enable.
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic               ce,
    // APB slave.
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [7:0]         paddr,
    input  wire logic [31:0]        pwdata,
    input  wire logic               pready,
    input  wire logic               pslverr,
    // Loop and monitor.
    input  wire logic               cycle_strobe,
    input  wire plc_pkg::plc_err_t  loop_error,
    input  wire logic [15:0]        duty_out,
    input  wire plc_pkg::plc_chan_t adc_sel
);
    import plc_pkg::*;
    logic [7:0]        lim_reg;
    logic [31:0]       cnt_reg;
    logic [1:0]        sel_reg;
    wire  logic [1:0]  sel_w    = adc_sel;
    wire  logic [15:0] lim_duty = {lim_reg[`PLC_LIMIT_MSB:`PLC_LIMIT_LSB], 10'h000};
    wire  logic        wr_lim   = psel && penable && pwrite && ce
                                  && (paddr == `PLC_DUTY_LIMIT_OFF);
    // The slot counter restarts at one so every slot, the first included, reads the same.
    // It counts enabled cycles only, since the scheduler freezes while ce is low.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lim_reg <= `PLC_DUTY_LIMIT_RST;
            cnt_reg <= 32'h0;
            sel_reg <= 2'h0;
        end else begin
            if (wr_lim) lim_reg <= pwdata[7:0];
            if (ce) begin
                cnt_reg <= (sel_w != sel_reg) ? 32'h1 : cnt_reg + 32'h1;
                sel_reg <= sel_w;
            end
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_high_hit;
        cycle_strobe && ce && lim_reg[`PLC_HIGH_SAT_BIT] && (loop_error > $signed(`PLC_WIN_RST));
    endsequence
    sequence s_low_hit;
        cycle_strobe && ce && lim_reg[`PLC_LOW_SAT_BIT] && (loop_error < -$signed(`PLC_WIN_RST));
    endsequence
    AST_READY_ZERO_WAIT: assert property (psel && penable |-> pready)
        else $error("pready low in access phase");
    AST_ERR_ONLY_ACCESS: assert property (pslverr |-> psel && penable)
        else $error("pslverr outside access phase");
    AST_ERR_UNMAPPED: assert property (psel && penable && (paddr > `PLC_DUTY_STAT_OFF
        || paddr[1:0] != 2'h0) |-> pslverr) else $error("unmapped access not refused");
    AST_DUTY_HOLD: assert property (!(cycle_strobe && ce) |=> $stable(duty_out))
        else $error("duty moved without a strobe");
    AST_HIGH_SAT: assert property (s_high_hit |=> duty_out == lim_duty)
        else $error("high saturation missed");
    AST_LOW_SAT: assert property (s_low_hit |=> duty_out == 16'h0000)
        else $error("low saturation missed");
    AST_DUTY_CLAMP: assert property (cycle_strobe && ce |=> duty_out <= lim_duty)
        else $error("duty above limit");
    AST_ADC_ORDER: assert property ($changed(sel_w) |->
        sel_w == (($past(sel_w) == 2'h2) ? 2'h0 : $past(sel_w) + 2'h1))
        else $error("monitor channel order broken");
    AST_SLOT_LEN: assert property ($changed(sel_w) |-> cnt_reg == SLOT_CYCLES)
        else $error("monitor slot length wrong");
endmodule : plc_loop_monitor
`default_nettype wire

// [plc_host_model.sv]
// Purpose: Configuring host that reaches the compensator over APB.
// Assumes: Caller enters xfer anywhere; each transfer starts on the next edge.
// Notes:   Zero or more wait states are accepted; only the bench timeout ends a wait.
`timescale 1ns/1ps
`default_nettype none
module plc_host_model (
    // Bus clock.
    input  wire logic        pclk,
    // Request.
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [7:0]       paddr,
    output logic [31:0]      pwdata,
    // Answer.
    input  wire logic        pready,
    input  wire logic        pslverr,
    input  wire logic [31:0] prdata
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end
    // Configuration only ever arrives through these transfers.
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
endmodule : plc_host_model
`default_nettype wire

// [pwm_loop_compensator_monitor_test.sv]
// Purpose: Self-checking bench for the loop compensator.
// Assumes: Window registers stay at reset; share line idle; loop off only briefly.
// Notes:   Monitor slots are shortened to eight cycles.
`timescale 1ns/1ps
`default_nettype none
module pwm_loop_compensator_monitor_test;
    import plc_pkg::*;
    localparam int SLOT = 8;
    logic        pclk, presetn, ce, cycle_strobe, psel, penable, pwrite, pready, pslverr;
    plc_err_t    loop_error;
    plc_chan_t   adc_sel;
    logic [7:0]  adc_data, share_in, share_out, temp_val, paddr;
    logic [31:0] pwdata, prdata;
    logic [15:0] duty_out;
    int          mismatches, checks;
    always #5 pclk = ~pclk;
    always @(posedge pclk) adc_data <= (adc_sel == PLC_CH_VOLT) ? 8'h5A :
                                       (adc_sel == PLC_CH_CURR) ? 8'h3C : temp_val;
    plc_host_model u_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata));
    plc_loop_core #(.SLOT_CYCLES(SLOT)) u_dut (.pclk(pclk), .presetn(presetn), .ce(ce),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .pslverr(pslverr), .prdata(prdata), .cycle_strobe(cycle_strobe),
        .loop_error(loop_error), .duty_out(duty_out), .adc_sel(adc_sel),
        .adc_data(adc_data), .share_in(share_in), .share_out(share_out));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic experr);
        logic [31:0] q;
        logic        e;
        u_host.xfer(1'b0, a, 32'h0, q, e);
        chk(q, exp);
        chk({31'h0, e}, {31'h0, experr});
    endtask : rd
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        u_host.xfer(1'b1, a, d, q, e);
    endtask : wr
    task automatic strobe(input plc_err_t e, input logic [15:0] exp);
        @(posedge pclk);
        cycle_strobe <= 1'b1;
        loop_error <= e;
        @(posedge pclk);
        cycle_strobe <= 1'b0;
        #1;
        chk({16'h0, duty_out}, {16'h0, exp});
    endtask : strobe
    task automatic t_regs();
        logic [7:0] a;
        rd(8'h00, 32'hE8, 1'b0);
        rd(8'h3C, 32'h400, 1'b0);
        rd(8'h44, 32'h02, 1'b0);
        for (int i = 0; i < 11; i++) begin
            a = 8'h04 + 8'(i * 4);
            rd(a, 32'h0, 1'b0);
            wr(a, {24'h0, 8'hA5 ^ 8'(i)});
            rd(a, {24'h0, 8'hA5 ^ 8'(i)}, 1'b0);
            wr(a, 32'h0);
        end
    endtask : t_regs
    task automatic t_refuse();
        rd(8'h50, 32'h0, 1'b1);
        rd(8'h06, 32'h0, 1'b1);
        wr(8'h4C, 32'hFFFF);
        rd(8'h4C, 32'h0, 1'b0);
    endtask : t_refuse
    task automatic t_sat();
        // Saturation is set only with a modest limit and a low output.
        wr(8'h00, 32'h83);
        strobe(16'sh0500, 16'h8000);
        strobe(-16'sh0500, 16'h0000);
        wr(8'h04, 32'h10);
        strobe(16'sh0100, 16'h0100);
        strobe(16'sh0400, 16'h0400);
        rd(8'h4C, 32'h400, 1'b0);
        wr(8'h24, 32'hC0);
        strobe(16'sh0100, 16'h0500);
        strobe(16'sh0100, 16'h0600);
        wr(8'h00, 32'h40);
        strobe(16'sh0500, 16'h0B00);
        strobe(16'sh7000, 16'h4000);
        strobe(-16'sh7000, 16'h0000);
        wr(8'h00, 32'h81);
        strobe(16'sh0500, 16'h0500);
        wr(8'h00, 32'h82);
        strobe(-16'sh0480, 16'h0080);
        // A frozen core ignores even a strobe that would saturate.
        @(posedge pclk);
        ce <= 1'b0;
        strobe(16'sh0500, 16'h0080);
        @(posedge pclk);
        ce <= 1'b1;
        wr(8'h44, 32'h0);
        strobe(16'sh0100, 16'h0080);
        wr(8'h44, 32'h2);
    endtask : t_sat
    task automatic t_mon();
        repeat (SLOT * 9) @(posedge pclk);
        rd(8'h30, 32'h5A, 1'b0);
        rd(8'h34, 32'h3C, 1'b0);
        rd(8'h38, 32'h19, 1'b0);
        wr(8'h48, 32'h40);
        temp_val <= 8'h23;
        repeat (SLOT * 9) @(posedge pclk);
        rd(8'h38, 32'h23, 1'b0);
        rd(8'h34, 32'h3E, 1'b0);
        chk({24'h0, share_out}, 32'h3E);
    endtask : t_mon
    task automatic end_of_test();
        $display("checks=%0d mismatches=%0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_of_test
    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        ce = 1'b1;
        cycle_strobe = 1'b0;
        loop_error = 16'sh0000;
        share_in = 8'h00;
        temp_val = 8'h19;
        mismatches = 0;
        checks = 0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_refuse();
        t_sat();
        t_mon();
        end_of_test();
    end
    // The whole sequence needs well under a thousand cycles.
    initial begin
        repeat (5000) @(posedge pclk);
        mismatches++;
        end_of_test();
    end
endmodule : pwm_loop_compensator_monitor_test
bind plc_loop_core plc_loop_monitor #(.SLOT_CYCLES(SLOT_CYCLES)) u_mon (.pclk(pclk),
    .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .cycle_strobe(cycle_strobe), .loop_error(loop_error), .duty_out(duty_out),
    .adc_sel(adc_sel));
`default_nettype wire
